// File: rtl/tpgio_defs.vh
`ifndef TPGIO_DEFS_VH
`define TPGIO_DEFS_VH
// Register offsets (byte addresses on the register port)
`define TPGIO_OFS_A_LATCH 8'h00
`define TPGIO_OFS_B_LATCH 8'h01
`define TPGIO_OFS_C_LATCH 8'h02
`define TPGIO_OFS_A_DIR 8'h04
`define TPGIO_OFS_B_DIR 8'h05
`define TPGIO_OFS_C_DIR 8'h06
`define TPGIO_OFS_A_PULL 8'h08
`define TPGIO_OFS_C_PULL 8'h0a
`define TPGIO_OFS_KBD_EN 8'h0c
`define TPGIO_OFS_KBD_POL 8'h0d
`define TPGIO_OFS_ADC_SEL 8'h0e
// Reset values
`define TPGIO_RST_DIR 8'h00
`define TPGIO_RST_PULL 8'h00
`define TPGIO_RST_KBD 8'h00
`define TPGIO_RST_ADC 8'h1f
// ADC channel select field
`define TPGIO_ADC_SEL_W 5
`define TPGIO_ADC_A_BASE 5'h08
`endif

// File: rtl/tpgio_top.v
// Function
// - Data latches per pin, untouched by reset
// - Direction one enables output buffer driving latch
// - Reset clears all direction bits
// - Direction bits readable, writable, per pin
// - Port A read: output bits give latch
// - Port B read: output bits give latch
// - Input bits read synchronised pin level
// - Latch writes always land, input unaffected
// - Port A pullup when enabled and input
// - Output direction disables pullup always
// - Keyboard enable makes port A pin interrupt
// - Keyboard pins pick pullup/pulldown from polarity
// - ADC selected pin forced analog input
// - Port B eight bits, no pullups
// - Port C only seven bits
// - Port C read: latch or pin level
// - Port C pullups only for enabled inputs
`timescale 1ns/1ps
`default_nettype none
`include "tpgio_defs.vh"
module tpgio_top #(
    parameter A_W = 8,
    parameter B_W = 8,
    parameter C_W = 7
) (
    // Clock and reset
    input wire clk,
    input wire arst_n,
    // Register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // Port A pins
    input wire [A_W-1:0] first_port_in,
    output reg [A_W-1:0] first_port_out,
    output reg [A_W-1:0] first_port_oe,
    output reg [A_W-1:0] first_port_pullup,
    output reg [A_W-1:0] first_port_pulldown,
    output reg [A_W-1:0] analog_inputs_upper,
    output reg [A_W-1:0] keyboard_inputs,
    // Port B pins
    input wire [B_W-1:0] second_port_in,
    output reg [B_W-1:0] second_port_out,
    output reg [B_W-1:0] second_port_oe,
    output reg [B_W-1:0] analog_inputs_lower,
    // Port C pins
    input wire [C_W-1:0] third_port_in,
    output reg [C_W-1:0] third_port_out,
    output reg [C_W-1:0] third_port_oe,
    output reg [C_W-1:0] third_port_pullup
);

// ----------------------------------------
// State
// ----------------------------------------
reg [A_W-1:0] first_port_latch_r;
reg [B_W-1:0] second_port_latch_r;
reg [C_W-1:0] third_port_latch_r;
reg [A_W-1:0] first_port_direction_r;
reg [B_W-1:0] second_port_direction_r;
reg [C_W-1:0] third_port_direction_r;
reg [A_W-1:0] first_port_pullup_enable_r;
reg [C_W-1:0] third_port_pullup_enable_r;
reg [A_W-1:0] keyboard_pin_enables_r;
reg [A_W-1:0] keyboard_polarity_r;
reg [`TPGIO_ADC_SEL_W-1:0] adc_sel_r;
wire [A_W-1:0] a_sync;
wire [B_W-1:0] b_sync;
wire [C_W-1:0] c_sync;
reg [7:0] rdata_nxt;
reg [A_W-1:0] a_analog;
reg [B_W-1:0] b_analog;

// ----------------------------------------
// Reset values at register width
// ----------------------------------------
localparam [7:0] RST_DIR8 = `TPGIO_RST_DIR;
localparam [7:0] RST_PULL8 = `TPGIO_RST_PULL;
localparam [7:0] RST_KBD8 = `TPGIO_RST_KBD;
localparam [7:0] RST_ADC8 = `TPGIO_RST_ADC;

// Latch or synchronised pin per bit
function [7:0] port_view;
    input [7:0] dir;
    input [7:0] latch;
    input [7:0] pin;
    begin
        port_view = (dir & latch) | (~dir & pin);
    end
endfunction

// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
// Only the second flop of each pair is read
genvar gs;
generate
    for (gs = 0; gs < A_W; gs = gs + 1) begin : g_sync_a
        reg meta_r;
        reg hold_r;
        always @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                meta_r <= 1'b0;
                hold_r <= 1'b0;
            end else begin
                meta_r <= first_port_in[gs];
                hold_r <= meta_r;
            end
        end
        assign a_sync[gs] = hold_r;
    end

    for (gs = 0; gs < B_W; gs = gs + 1) begin : g_sync_b
        reg meta_r;
        reg hold_r;
        always @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                meta_r <= 1'b0;
                hold_r <= 1'b0;
            end else begin
                meta_r <= second_port_in[gs];
                hold_r <= meta_r;
            end
        end
        assign b_sync[gs] = hold_r;
    end

    for (gs = 0; gs < C_W; gs = gs + 1) begin : g_sync_c
        reg meta_r;
        reg hold_r;
        always @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                meta_r <= 1'b0;
                hold_r <= 1'b0;
            end else begin
                meta_r <= third_port_in[gs];
                hold_r <= meta_r;
            end
        end
        assign c_sync[gs] = hold_r;
    end
endgenerate

// ----------------------------------------
// Data latches, no reset
// ----------------------------------------
// Written whatever the direction bit
always @(posedge clk) begin
    if (reg_wr && reg_addr == `TPGIO_OFS_A_LATCH) begin
        first_port_latch_r <= reg_wdata[A_W-1:0];
    end
    if (reg_wr && reg_addr == `TPGIO_OFS_B_LATCH) begin
        second_port_latch_r <= reg_wdata[B_W-1:0];
    end
    if (reg_wr && reg_addr == `TPGIO_OFS_C_LATCH) begin
        third_port_latch_r <= reg_wdata[C_W-1:0];
    end
end

// ----------------------------------------
// Control registers
// ----------------------------------------
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        // Narrow registers take the low bits of the reset value
        first_port_direction_r <= RST_DIR8[A_W-1:0];
        second_port_direction_r <= RST_DIR8[B_W-1:0];
        third_port_direction_r <= RST_DIR8[C_W-1:0];
        first_port_pullup_enable_r <= RST_PULL8[A_W-1:0];
        third_port_pullup_enable_r <= RST_PULL8[C_W-1:0];
        keyboard_pin_enables_r <= RST_KBD8[A_W-1:0];
        keyboard_polarity_r <= RST_KBD8[A_W-1:0];
        adc_sel_r <= RST_ADC8[`TPGIO_ADC_SEL_W-1:0];
    end else if (reg_wr) begin
        case (reg_addr)
            `TPGIO_OFS_A_DIR: begin
                first_port_direction_r <= reg_wdata[A_W-1:0];
            end
            `TPGIO_OFS_B_DIR: begin
                second_port_direction_r <= reg_wdata[B_W-1:0];
            end
            `TPGIO_OFS_C_DIR: begin
                third_port_direction_r <= reg_wdata[C_W-1:0];
            end
            `TPGIO_OFS_A_PULL: begin
                first_port_pullup_enable_r <= reg_wdata[A_W-1:0];
            end
            `TPGIO_OFS_C_PULL: begin
                third_port_pullup_enable_r <= reg_wdata[C_W-1:0];
            end
            `TPGIO_OFS_KBD_EN: begin
                keyboard_pin_enables_r <= reg_wdata[A_W-1:0];
            end
            `TPGIO_OFS_KBD_POL: begin
                keyboard_polarity_r <= reg_wdata[A_W-1:0];
            end
            `TPGIO_OFS_ADC_SEL: begin
                adc_sel_r <= reg_wdata[`TPGIO_ADC_SEL_W-1:0];
            end
            default: begin
            end
        endcase
    end
end

// ----------------------------------------
// Port read views
// ----------------------------------------
wire [7:0] a_view;
wire [7:0] b_view;
wire [7:0] c_view;
// Output bits show the latch, input bits the pin
assign a_view = port_view(first_port_direction_r, first_port_latch_r,
    a_sync);
assign b_view = port_view(second_port_direction_r, second_port_latch_r,
    b_sync);
assign c_view = port_view({1'b0, third_port_direction_r},
    {1'b0, third_port_latch_r}, {1'b0, c_sync});

// ----------------------------------------
// Read mux
// ----------------------------------------
always @* begin
    rdata_nxt = 8'h00;
    case (reg_addr)
        `TPGIO_OFS_A_LATCH: rdata_nxt = a_view;
        `TPGIO_OFS_B_LATCH: rdata_nxt = b_view;
        `TPGIO_OFS_C_LATCH: rdata_nxt = c_view;
        `TPGIO_OFS_A_DIR: rdata_nxt = first_port_direction_r;
        `TPGIO_OFS_B_DIR: rdata_nxt = second_port_direction_r;
        `TPGIO_OFS_C_DIR: rdata_nxt = {1'b0, third_port_direction_r};
        `TPGIO_OFS_A_PULL: rdata_nxt = first_port_pullup_enable_r;
        `TPGIO_OFS_C_PULL: rdata_nxt = {1'b0, third_port_pullup_enable_r};
        `TPGIO_OFS_KBD_EN: rdata_nxt = keyboard_pin_enables_r;
        `TPGIO_OFS_KBD_POL: rdata_nxt = keyboard_polarity_r;
        `TPGIO_OFS_ADC_SEL: rdata_nxt = {3'h0, adc_sel_r};
        default: rdata_nxt = 8'h00;
    endcase
end

// Read data stands one cycle, zero otherwise
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        reg_rdata <= 8'h00;
    end else if (reg_rd) begin
        reg_rdata <= rdata_nxt;
    end else begin
        reg_rdata <= 8'h00;
    end
end

// ----------------------------------------
// ADC channel decode
// ----------------------------------------
// One-hot pin of a converter channel within a port window
function [7:0] chan_pin;
    input [4:0] sel;
    input [4:0] base;
    reg [4:0] ofs;
    begin
        ofs = sel - base;
        chan_pin = 8'h00;
        if (sel >= base && ofs < 5'h08) begin
            chan_pin[ofs[2:0]] = 1'b1;
        end
    end
endfunction

always @* begin
    a_analog = chan_pin(adc_sel_r, `TPGIO_ADC_A_BASE);
    b_analog = chan_pin(adc_sel_r, 5'h00);
end

// ----------------------------------------
// Per-pin control, port A
// ----------------------------------------
wire [A_W-1:0] a_oe_nxt;
wire [A_W-1:0] a_pu_nxt;
wire [A_W-1:0] a_pd_nxt;
wire [A_W-1:0] a_kbd_nxt;
genvar ga;
generate
    for (ga = 0; ga < A_W; ga = ga + 1) begin : g_pin_a
        wire is_out;
        wire is_in;
        wire kbd_pin;
        wire kbd_low;
        assign is_out = first_port_direction_r[ga];
        // Converter-selected pin loses all digital control
        assign is_in = ~is_out & ~a_analog[ga];
        assign kbd_pin = keyboard_pin_enables_r[ga];
        assign kbd_low = keyboard_polarity_r[ga];
        assign a_oe_nxt[ga] = is_out & ~a_analog[ga];
        // Keyboard pin: polarity picks the pull
        assign a_pu_nxt[ga] = is_in & (kbd_pin ? ~kbd_low :
            first_port_pullup_enable_r[ga]);
        assign a_pd_nxt[ga] = is_in & kbd_pin & kbd_low;
        assign a_kbd_nxt[ga] = kbd_pin & ~a_analog[ga] & a_sync[ga];
    end
endgenerate

// ----------------------------------------
// Per-pin control, port B
// ----------------------------------------
wire [B_W-1:0] b_oe_nxt;
genvar gb;
generate
    for (gb = 0; gb < B_W; gb = gb + 1) begin : g_pin_b
        // No pull of any kind on this port
        assign b_oe_nxt[gb] = second_port_direction_r[gb] &
            ~b_analog[gb];
    end
endgenerate

// ----------------------------------------
// Per-pin control, port C
// ----------------------------------------
wire [C_W-1:0] c_oe_nxt;
wire [C_W-1:0] c_pu_nxt;
genvar gc;
generate
    for (gc = 0; gc < C_W; gc = gc + 1) begin : g_pin_c
        wire is_out;
        assign is_out = third_port_direction_r[gc];
        assign c_oe_nxt[gc] = is_out;
        // Pullup only while the pin is an input
        assign c_pu_nxt[gc] = ~is_out &
            third_port_pullup_enable_r[gc];
    end
endgenerate

// ----------------------------------------
// Pin drive
// ----------------------------------------
always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        first_port_out <= {A_W{1'b0}};
        first_port_oe <= {A_W{1'b0}};
        first_port_pullup <= {A_W{1'b0}};
        first_port_pulldown <= {A_W{1'b0}};
        analog_inputs_upper <= {A_W{1'b0}};
        keyboard_inputs <= {A_W{1'b0}};
        second_port_out <= {B_W{1'b0}};
        second_port_oe <= {B_W{1'b0}};
        analog_inputs_lower <= {B_W{1'b0}};
        third_port_out <= {C_W{1'b0}};
        third_port_oe <= {C_W{1'b0}};
        third_port_pullup <= {C_W{1'b0}};
    end else begin
        // Every pin output leaves a flop, one cycle behind
        first_port_out <= first_port_latch_r;
        first_port_oe <= a_oe_nxt;
        first_port_pullup <= a_pu_nxt;
        first_port_pulldown <= a_pd_nxt;
        analog_inputs_upper <= a_analog;
        keyboard_inputs <= a_kbd_nxt;
        second_port_out <= second_port_latch_r;
        second_port_oe <= b_oe_nxt;
        analog_inputs_lower <= b_analog;
        third_port_out <= third_port_latch_r;
        third_port_oe <= c_oe_nxt;
        third_port_pullup <= c_pu_nxt;
    end
end

endmodule
`default_nettype wire

// File: verification/tpgio_pins.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Pad model
// ----------------------------------------
module tpgio_pins #(
    parameter W = 8
) (
    // Pad controls
    input wire logic clk,
    input wire logic [W-1:0] oe,
    input wire logic [W-1:0] out,
    input wire logic [W-1:0] pu,
    input wire logic [W-1:0] pd,
    // Far side drive
    input wire logic [W-1:0] ext,
    input wire logic ext_en,
    output logic [W-1:0] lvl
);
    logic t_r = 1'b0;
    always @(posedge clk) t_r <= ~t_r;
    // Floating pads wander every cycle
    always_comb begin
        lvl = oe & out | ~oe & (ext_en ? ext : pu | ~pd & {W{t_r}});
    end
endmodule
`default_nettype wire

// File: verification/tpgio_checker.sv
`timescale 1ns/1ps
`default_nettype none
module tpgio_checker #(
    parameter A_W = 8,
    parameter B_W = 8,
    parameter C_W = 7
) (
    // Register port
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Pads
    input wire logic [A_W-1:0] first_port_out,
    input wire logic [A_W-1:0] first_port_oe,
    input wire logic [A_W-1:0] first_port_pullup,
    input wire logic [A_W-1:0] first_port_pulldown,
    input wire logic [A_W-1:0] analog_inputs_upper,
    input wire logic [B_W-1:0] second_port_out,
    input wire logic [B_W-1:0] second_port_oe,
    input wire logic [B_W-1:0] analog_inputs_lower,
    input wire logic [C_W-1:0] third_port_oe,
    input wire logic [C_W-1:0] third_port_pullup
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_rdata_idle_zero: assert property (
        !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read");
    a_unmapped_read_zero: assert property (
        reg_rd && reg_addr == 8'h03 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_c_top_bit: assert property (
        reg_rd && reg_addr == 8'h02 |=> !reg_rdata[7])
        else $error("port c bit 7 set");
    a_a_latch_out: assert property (
        reg_wr && reg_addr == 8'h00 |=> ##1
        first_port_out == $past(reg_wdata, 2))
        else $error("port a out not latch");
    a_b_latch_out: assert property (
        reg_wr && reg_addr == 8'h01 |=> ##1
        second_port_out == $past(reg_wdata, 2))
        else $error("port b out not latch");
    a_oe_after_reset: assert property (
        $rose(arst_n) |-> first_port_oe == 0 && second_port_oe == 0
        && third_port_oe == 0)
        else $error("drivers on after reset");
    a_pull_not_out: assert property (
        (first_port_oe & first_port_pullup) == 0
        && (third_port_oe & third_port_pullup) == 0)
        else $error("pullup on driven pin");
    a_analog_a_free: assert property (
        (analog_inputs_upper & (first_port_oe | first_port_pullup
        | first_port_pulldown)) == 0)
        else $error("analog port a pin still controlled");
    a_analog_b_free: assert property (
        (analog_inputs_lower & second_port_oe) == 0)
        else $error("analog port b pin driven");
    c_read: cover property (reg_rd);
    c_pull: cover property (first_port_pullup != 0);
    c_analog: cover property (analog_inputs_upper != 0);
endmodule
bind tpgio_top tpgio_checker #(.A_W(A_W), .B_W(B_W), .C_W(C_W))
    u_tpgio_checker (
    .clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .first_port_out, .first_port_oe, .first_port_pullup, .first_port_pulldown,
    .analog_inputs_upper, .second_port_out, .second_port_oe,
    .analog_inputs_lower, .third_port_oe, .third_port_pullup);
`default_nettype wire

// File: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] ext = 8'h00;
    logic ext_en = 1'b1;
    logic [7:0] no_pull = 8'h00;
    int fails = 0;
    int checked = 0;
    wire [7:0] reg_rdata, first_port_in, first_port_out, first_port_oe;
    wire [7:0] first_port_pullup, first_port_pulldown, analog_inputs_upper;
    wire [7:0] keyboard_inputs, second_port_in, second_port_out;
    wire [7:0] second_port_oe, analog_inputs_lower;
    wire [6:0] third_port_in, third_port_out, third_port_oe, third_port_pullup;
    tpgio_top u_tpgio_top (
        .clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .first_port_in, .first_port_out, .first_port_oe, .first_port_pullup,
        .first_port_pulldown, .analog_inputs_upper, .keyboard_inputs,
        .second_port_in, .second_port_out, .second_port_oe,
        .analog_inputs_lower, .third_port_in, .third_port_out,
        .third_port_oe, .third_port_pullup);
    tpgio_pins #(.W(8)) u_tpgio_pins_a (.clk, .oe(first_port_oe),
        .out(first_port_out), .pu(first_port_pullup),
        .pd(first_port_pulldown), .ext, .ext_en, .lvl(first_port_in));
    tpgio_pins #(.W(8)) u_tpgio_pins_b (.clk, .oe(second_port_oe),
        .out(second_port_out), .pu(no_pull), .pd(no_pull), .ext, .ext_en,
        .lvl(second_port_in));
    tpgio_pins #(.W(7)) u_tpgio_pins_c (.clk, .oe(third_port_oe),
        .out(third_port_out), .pu(third_port_pullup), .pd(no_pull[6:0]),
        .ext(ext[6:0]), .ext_en, .lvl(third_port_in));
    initial forever #5 clk = ~clk;
    task automatic final_report;
        if (fails == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            fails++;
            $display("ERROR %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask
    task automatic s_reset;
        rd(8'h04, 8'h00);
        rd(8'h06, 8'h00);
        rd(8'h0a, 8'h00);
        rd(8'h0d, 8'h00);
        rd(8'h0e, 8'h1f);
        chk(first_port_oe | second_port_oe, 8'h00);
    endtask
    task automatic s_ports;
        logic [7:0] m;
        ext <= 8'ha3;
        for (int p = 0; p < 3; p++) begin
            m = (p == 2) ? 8'h7f : 8'hff;
            wr(p[7:0], 8'h5a);
            repeat (3) @(posedge clk);
            rd(p[7:0], 8'ha3 & m);
            wr(8'h04 + p[7:0], 8'hcf);
            rd(8'h04 + p[7:0], 8'hcf & m);
            repeat (2) @(posedge clk);
            rd(p[7:0], 8'h6a & m);
            m = (p == 0) ? first_port_oe ^ m : (p == 1) ?
                second_port_oe ^ m : {1'b0, third_port_oe} ^ m;
            chk(m, 8'h30);
        end
    endtask
    task automatic s_pull;
        ext_en <= 1'b0;
        wr(8'h08, 8'hff);
        wr(8'h0a, 8'hff);
        repeat (3) @(posedge clk);
        chk(first_port_pullup, 8'h30);
        chk({1'b0, third_port_pullup}, 8'h30);
        rd(8'h00, 8'h7a);
        wr(8'h0c, 8'hff);
        wr(8'h0d, 8'h20);
        repeat (5) @(posedge clk);
        #1;
        chk(first_port_pulldown, 8'h20);
        chk(keyboard_inputs & 8'h30, 8'h10);
    endtask
    task automatic s_adc;
        wr(8'h0e, 8'hec);
        rd(8'h0e, 8'h0c);
        repeat (2) @(posedge clk);
        chk(analog_inputs_upper, 8'h10);
        chk(first_port_pullup, 8'h00);
        wr(8'h0e, 8'h03);
        wr(8'h03, 8'hff);
        rd(8'h03, 8'h00);
        chk(analog_inputs_lower, 8'h08);
    endtask
    task automatic s_keep;
        wr(8'h01, 8'h96);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        rd(8'h05, 8'h00);
        wr(8'h05, 8'hff);
        rd(8'h01, 8'h96);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        s_reset();
        s_ports();
        s_pull();
        s_adc();
        s_keep();
        final_report();
    end
    initial begin
        #50000;
        fails++;
        final_report();
    end
endmodule
`default_nettype wire
